// *** hw/usdp_pkg.sv ***
// Constants and types shared by the shadow data port
package usdp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] ADDR_DATA12 = 32'h5000_1060;
  localparam logic [31:0] ADDR_CTRL = 32'h5000_1070;
  localparam logic [31:0] ADDR_STAT = 32'h5000_1074;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_BIT = 1;
  localparam int STAT_AVAIL_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_TX_HOLDING_EMPTY_BIT = 5;
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 32;
  localparam int TX_DEPTH = 16;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    USDP_SEL_NONE = 2'b00,
    USDP_SEL_DATA = 2'b01,
    USDP_SEL_CTRL = 2'b10,
    USDP_SEL_STAT = 2'b11
  } usdp_sel_t;
  typedef enum logic [1:0] {
    USDP_PH_IDLE = 2'b00,
    USDP_PH_READ = 2'b01,
    USDP_PH_WRITE = 2'b10
  } usdp_phase_t;
endpackage : usdp_pkg

// *** hw/usdp_top.sv ***
// Shadow receive/transmit data port with FIFOs and AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps

module usdp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Fill level
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign out_valid = (level != '0);
  // Pop frees a slot in the same cycle, so full plus read still accepts
  assign in_ready = (level != ($clog2(D+1))'(D)) || out_ready;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : usdp_fifo

module usdp_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Received characters from the deserialisers
  input wire logic SER_RX_VALID,
  input wire logic [7:0] SER_RX_DATA,
  input wire logic IR_RX_VALID,
  input wire logic [7:0] IR_RX_DATA,
  // Characters to the serialisers
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  output logic SER_TX_VALID,
  output logic IR_TX_VALID_N
);
  localparam int RXL = $clog2(usdp_pkg::RX_DEPTH + 1);
  localparam int TXL = $clog2(usdp_pkg::TX_DEPTH + 1);

  usdp_pkg::usdp_phase_t phase;
  usdp_pkg::usdp_sel_t dsel;
  logic [1:0] ctrl;
  logic fifo_en;
  logic ir_mode;
  logic acc;
  logic rd_pop;
  logic stat_rd;
  logic wr_data;
  logic rx_in_valid;
  logic [7:0] rx_in_data;
  logic [7:0] rx_hold;
  logic rx_hold_full;
  logic overrun;
  logic avail;
  logic tx_holding_empty;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic [7:0] rxf_out_data;
  logic [RXL-1:0] rxf_level;
  logic [7:0] tx_hold;
  logic tx_hold_full;
  logic txf_in_ready;
  logic txf_out_valid;
  logic txf_out_ready;
  logic [7:0] txf_out_data;
  logic [TXL-1:0] txf_level;
  logic stage_free;
  logic [31:0] next_rdata;

  // Sixteen aliases share the port; only the twelfth is mapped here
  function automatic usdp_pkg::usdp_sel_t decode(input logic [31:0] a);
    if (a == usdp_pkg::ADDR_DATA12) begin
      decode = usdp_pkg::USDP_SEL_DATA;
    end else if (a == usdp_pkg::ADDR_CTRL) begin
      decode = usdp_pkg::USDP_SEL_CTRL;
    end else if (a == usdp_pkg::ADDR_STAT) begin
      decode = usdp_pkg::USDP_SEL_STAT;
    end else begin
      decode = usdp_pkg::USDP_SEL_NONE;
    end
  endfunction : decode

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign fifo_en = ctrl[usdp_pkg::CTRL_FIFO_EN_BIT];
  assign ir_mode = ctrl[usdp_pkg::CTRL_IR_BIT];
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign rd_pop = acc && !HWRITE && (decode(HADDR) == usdp_pkg::USDP_SEL_DATA);
  assign stat_rd = acc && !HWRITE && (decode(HADDR) == usdp_pkg::USDP_SEL_STAT);
  assign wr_data = (phase == usdp_pkg::USDP_PH_WRITE) && (dsel == usdp_pkg::USDP_SEL_DATA);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase <= usdp_pkg::USDP_PH_IDLE;
      dsel <= usdp_pkg::USDP_SEL_NONE;
    end else if (acc) begin
      phase <= HWRITE ? usdp_pkg::USDP_PH_WRITE : usdp_pkg::USDP_PH_READ;
      dsel <= decode(HADDR);
    end else begin
      phase <= usdp_pkg::USDP_PH_IDLE;
      dsel <= usdp_pkg::USDP_SEL_NONE;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= usdp_pkg::CTRL_RESET;
    end else if ((phase == usdp_pkg::USDP_PH_WRITE) && (dsel == usdp_pkg::USDP_SEL_CTRL)) begin
      ctrl <= HWDATA[1:0];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    next_rdata = usdp_pkg::WORD_ZERO;
    unique case (decode(HADDR))
      usdp_pkg::USDP_SEL_DATA: next_rdata[7:0] = fifo_en ? rxf_out_data : rx_hold;
      usdp_pkg::USDP_SEL_CTRL: next_rdata[1:0] = ctrl;
      usdp_pkg::USDP_SEL_STAT: begin
        next_rdata[usdp_pkg::STAT_AVAIL_BIT] = avail;
        next_rdata[usdp_pkg::STAT_OVR_BIT] = overrun;
        next_rdata[usdp_pkg::STAT_TX_HOLDING_EMPTY_BIT] = tx_holding_empty;
      end
      usdp_pkg::USDP_SEL_NONE: next_rdata = usdp_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= usdp_pkg::WORD_ZERO;
    end else if (acc && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  assign rx_in_valid = ir_mode ? IR_RX_VALID : SER_RX_VALID;
  assign rx_in_data = ir_mode ? IR_RX_DATA : SER_RX_DATA;
  assign avail = fifo_en ? rxf_out_valid : rx_hold_full;

  usdp_fifo #(
    .W(usdp_pkg::DATA_W),
    .D(usdp_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .in_valid(fifo_en && rx_in_valid),
    .in_ready(rxf_in_ready),
    .in_data(rx_in_data),
    .out_valid(rxf_out_valid),
    .out_ready(fifo_en && rd_pop),
    .out_data(rxf_out_data),
    .level(rxf_level)
  );

  // Arrival wins over a read in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_hold <= usdp_pkg::DATA_RESET;
      rx_hold_full <= 1'b0;
    end else if (!fifo_en && rx_in_valid) begin
      rx_hold <= rx_in_data;
      rx_hold_full <= 1'b1;
    end else if (rd_pop) begin
      rx_hold_full <= 1'b0;
    end
  end

  // Sticky; cleared by a status read, a new overrun wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      overrun <= 1'b0;
    end else if (rx_in_valid && (fifo_en ? !rxf_in_ready : (rx_hold_full && !rd_pop))) begin
      overrun <= 1'b1;
    end else if (stat_rd) begin
      overrun <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  assign tx_holding_empty = fifo_en ? !txf_out_valid : !tx_hold_full;
  assign stage_free = (!SER_TX_VALID && IR_TX_VALID_N) || TX_READY;
  assign txf_out_ready = fifo_en && stage_free;

  usdp_fifo #(
    .W(usdp_pkg::DATA_W),
    .D(usdp_pkg::TX_DEPTH)
  ) u_tx_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .in_valid(fifo_en && wr_data),
    .in_ready(txf_in_ready),
    .in_data(HWDATA[7:0]),
    .out_valid(txf_out_valid),
    .out_ready(txf_out_ready),
    .out_data(txf_out_data),
    .level(txf_level)
  );

  // Write wins over the hand-off to the output stage
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_hold <= usdp_pkg::DATA_RESET;
      tx_hold_full <= 1'b0;
    end else if (!fifo_en && wr_data) begin
      tx_hold <= HWDATA[7:0];
      tx_hold_full <= 1'b1;
    end else if (!fifo_en && stage_free) begin
      tx_hold_full <= 1'b0;
    end
  end

  // Output stage; mode sampled at load so a frame never switches pins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_DATA <= usdp_pkg::DATA_RESET;
      SER_TX_VALID <= 1'b0;
      IR_TX_VALID_N <= 1'b1;
    end else if (stage_free) begin
      if ((fifo_en && txf_out_valid) || (!fifo_en && tx_hold_full)) begin
        TX_DATA <= fifo_en ? txf_out_data : tx_hold;
        SER_TX_VALID <= !ir_mode;
        IR_TX_VALID_N <= !ir_mode;
      end else begin
        SER_TX_VALID <= 1'b0;
        IR_TX_VALID_N <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bus_always_okay: assert property (@(posedge CLK) disable iff (!ARST_N)
    HREADYOUT && !HRESP) else $error("slave not ready or not OKAY");
  a_rx_overwrite_flag: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!fifo_en && rx_in_valid && rx_hold_full && !rd_pop) |=> (overrun && rx_hold == $past(rx_in_data)))
    else $error("unread byte not overwritten with overrun");
  a_rx_full_drop: assert property (@(posedge CLK) disable iff (!ARST_N)
    (fifo_en && rx_in_valid && !rxf_in_ready) |=> (overrun && $stable(rxf_level)))
    else $error("full receive FIFO changed or no overrun");
  a_rx_head_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    (fifo_en && rd_pop && rxf_out_valid) |=> (HRDATA[7:0] == $past(rxf_out_data)))
    else $error("read did not return FIFO head");
  a_rx_source_sel: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!fifo_en && rx_in_valid && ir_mode) |=> (rx_hold == $past(IR_RX_DATA)))
    else $error("infrared byte not captured");
  a_tx_write_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!fifo_en && wr_data) |=> (!tx_holding_empty && tx_hold == $past(HWDATA[7:0])))
    else $error("write did not fill holding register");
  a_tx_fifo_fill: assert property (@(posedge CLK) disable iff (!ARST_N)
    (fifo_en && wr_data && txf_level < TXL'(usdp_pkg::TX_DEPTH) && !txf_out_ready)
    |=> (txf_level == $past(txf_level) + 1'b1)) else $error("transmit FIFO did not accept write");
  a_tx_full_drop: assert property (@(posedge CLK) disable iff (!ARST_N)
    (fifo_en && wr_data && !txf_in_ready) |=> (txf_level == $past(txf_level)))
    else $error("write into full transmit FIFO not dropped");
  a_tx_one_pin: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(SER_TX_VALID && !IR_TX_VALID_N)) else $error("both transmit outputs active");

  c_rx_overrun: cover property (@(posedge CLK) disable iff (!ARST_N)
    fifo_en && rx_in_valid && !rxf_in_ready);
  c_tx_full: cover property (@(posedge CLK) disable iff (!ARST_N)
    fifo_en && wr_data && !txf_in_ready);
  c_ir_send: cover property (@(posedge CLK) disable iff (!ARST_N)
    !IR_TX_VALID_N && TX_READY);
endmodule : usdp_top

// *** testbench/usdp_far_uart.sv ***
// Far-side UART model: character source and stalling sink
`timescale 1ns/1ps

module usdp_far_uart (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Received characters
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data,
  output logic ir_rx_valid,
  output logic [7:0] ir_rx_data,
  // Transmitted characters
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic ser_tx_valid,
  input wire logic ir_tx_valid_n
);
  logic stall = 1'b1;
  logic [8:0] got [$];

  initial begin
    ser_rx_valid = 1'b0;
    ir_rx_valid = 1'b0;
    ser_rx_data = 8'h5a;
    ir_rx_data = 8'ha5;
  end

  // One char per pulse; lines inverted after it so a stale byte never looks fresh
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge clk);
    ir_rx_valid <= ir;
    ser_rx_valid <= !ir;
    ser_rx_data <= ir ? ~b : b;
    ir_rx_data <= ir ? b : ~b;
    @(posedge clk);
    ser_rx_valid <= 1'b0;
    ir_rx_valid <= 1'b0;
    ser_rx_data <= ~b;
    ir_rx_data <= ~b;
  endtask : send

  // Sink records which pin each char left on; may stall for long stretches
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !stall;
      if (tx_ready && (ser_tx_valid || !ir_tx_valid_n)) begin
        got.push_back({!ir_tx_valid_n, tx_data});
      end
    end
  end
endmodule : usdp_far_uart

// *** testbench/uart_shadow_data_port_tb.sv ***
// Self-checking bench for the shadow data port
`timescale 1ns/1ps

module uart_shadow_data_port_tb;
  typedef struct packed {
    logic [1:0] ctrl;
    logic link;
    logic [7:0] ch;
    logic [31:0] stat;
  } usdp_row_t;

  // Mode, input link, byte, expected status
  localparam usdp_row_t ROWS [4] = '{
    '{2'h0, 1'b0, 8'h5a, 32'h0000_0021},
    '{2'h2, 1'b1, 8'hc3, 32'h0000_0021},
    '{2'h0, 1'b1, 8'h77, 32'h0000_0020},
    '{2'h2, 1'b0, 8'h88, 32'h0000_0020}
  };

  logic clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic ser_rx_valid, ir_rx_valid, tx_ready, ser_tx_valid, ir_tx_valid_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ser_rx_data, ir_rx_data, tx_data;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  usdp_top u_dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SER_RX_VALID(ser_rx_valid), .SER_RX_DATA(ser_rx_data),
    .IR_RX_VALID(ir_rx_valid), .IR_RX_DATA(ir_rx_data), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .SER_TX_VALID(ser_tx_valid), .IR_TX_VALID_N(ir_tx_valid_n));

  usdp_far_uart u_far (.clk(clk), .arst_n(arst_n), .ser_rx_valid(ser_rx_valid),
    .ser_rx_data(ser_rx_data), .ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
    .tx_ready(tx_ready), .tx_data(tx_data), .ser_tx_valid(ser_tx_valid), .ir_tx_valid_n(ir_tx_valid_n));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single word transfer; waits on the answer rather than assuming a latency
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(what, exp, r);
  endtask : rchk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic pull(input string what, input logic [8:0] exp);
    int n;
    n = 0;
    while (u_far.got.size() == 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(what, {23'h0, exp}, (u_far.got.size() > 0) ? {23'h0, u_far.got.pop_front()} : 32'hffff_ffff);
  endtask : pull

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    {hsel, hwrite, htrans} = 4'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("data reset", usdp_pkg::ADDR_DATA12, 32'h0000_0000);
    rchk("ctrl reset", usdp_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk("stat reset", usdp_pkg::ADDR_STAT, 32'h0000_0020);
    rchk("unmapped", 32'h5000_1080, 32'h0000_0000);
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0003);
    rchk("ctrl rw", usdp_pkg::ADDR_CTRL, 32'h0000_0003);
    done("registers");
    u_far.stall <= 1'b0;
    foreach (ROWS[i]) begin
      wr(usdp_pkg::ADDR_CTRL, {30'h0, ROWS[i].ctrl});
      u_far.send(ROWS[i].link, ROWS[i].ch);
      rchk("status", usdp_pkg::ADDR_STAT, ROWS[i].stat);
      if (ROWS[i].stat[0]) rchk("rx byte", usdp_pkg::ADDR_DATA12, {24'h0, ROWS[i].ch});
      // Upper bits set on purpose; only the low byte may travel
      wr(usdp_pkg::ADDR_DATA12, {24'hff_ffff, ROWS[i].ch});
      pull("tx pin byte", {ROWS[i].ctrl[1], ROWS[i].ch});
    end
    done("table");
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0000);
    u_far.send(1'b0, 8'ha1);
    u_far.send(1'b0, 8'hb2);
    rchk("overrun", usdp_pkg::ADDR_STAT, 32'h0000_0023);
    rchk("rx latest", usdp_pkg::ADDR_DATA12, 32'h0000_00b2);
    rchk("stat after", usdp_pkg::ADDR_STAT, 32'h0000_0020);
    done("overwrite");
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i <= usdp_pkg::RX_DEPTH; i++) u_far.send(1'b0, 8'h40 + 8'(i));
    rchk("rx full", usdp_pkg::ADDR_STAT, 32'h0000_0023);
    for (int i = 0; i < usdp_pkg::RX_DEPTH; i++) rchk("rx head", usdp_pkg::ADDR_DATA12, 32'h0000_0040 + 32'(i));
    rchk("rx empty", usdp_pkg::ADDR_STAT, 32'h0000_0020);
    done("rx fifo");
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0000);
    u_far.stall <= 1'b1;
    wr(usdp_pkg::ADDR_DATA12, 32'h0000_0011);
    wr(usdp_pkg::ADDR_DATA12, 32'h0000_0022);
    rchk("holding full", usdp_pkg::ADDR_STAT, 32'h0000_0000);
    wr(usdp_pkg::ADDR_DATA12, 32'h0000_0033);
    u_far.stall <= 1'b0;
    pull("tx first", 9'h011);
    pull("tx overwrite", 9'h033);
    done("holding");
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0001);
    u_far.stall <= 1'b1;
    // One byte sits in the output stage, so depth plus two writes overfill
    for (int i = 0; i <= usdp_pkg::TX_DEPTH + 1; i++) wr(usdp_pkg::ADDR_DATA12, 32'h0000_0060 + 32'(i));
    rchk("tx full", usdp_pkg::ADDR_STAT, 32'h0000_0000);
    u_far.stall <= 1'b0;
    for (int i = 0; i <= usdp_pkg::TX_DEPTH; i++) pull("tx fifo", 9'h060 + 9'(i));
    repeat (50) @(posedge clk);
    chk("tx extra", 32'h0000_0000, 32'(u_far.got.size()));
    done("tx fifo");
    // Reset mid-run with a byte stuck in the output stage and one received
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0003);
    u_far.stall <= 1'b1;
    wr(usdp_pkg::ADDR_DATA12, 32'h0000_005e);
    u_far.send(1'b1, 8'h99);
    chk("ir pending", 32'h0000_0000, {31'h0, ir_tx_valid_n});
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst ser valid", 32'h0000_0000, {31'h0, ser_tx_valid});
    chk("rst ir valid", 32'h0000_0001, {31'h0, ir_tx_valid_n});
    chk("rst hrdata", 32'h0000_0000, hrdata);
    chk("rst hresp", 32'h0000_0000, {31'h0, hresp});
    arst_n <= 1'b1;
    u_far.stall <= 1'b0;
    @(posedge clk);
    rchk("ctrl after rst", usdp_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk("stat after rst", usdp_pkg::ADDR_STAT, 32'h0000_0020);
    // Both FIFOs must come back empty
    wr(usdp_pkg::ADDR_CTRL, 32'h0000_0001);
    rchk("fifos after rst", usdp_pkg::ADDR_STAT, 32'h0000_0020);
    repeat (20) @(posedge clk);
    chk("tx after rst", 32'h0000_0000, 32'(u_far.got.size()));
    done("reset");
    stop_test();
  end
endmodule : uart_shadow_data_port_tb
